//--- include/ptr_pkg.sv
// Constants, types and helpers for the telemetry readout block.
// Assumes a 10 MHz system clock and 14-bit converter results.
package ptr_pkg;

   // ------------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------------
   localparam int CLK_HZ             = 10_000_000;
   localparam int REFRESH_MS         = 100;
   localparam int REFRESH_CYCLES_DEF = REFRESH_MS * (CLK_HZ / 1000);

   // ------------------------------------------------------------------
   // Result format and command codes
   // ------------------------------------------------------------------
   localparam int          RESULT_W     = 14;
   localparam int          LOW_BYTE_MSB = 7;
   localparam int          HIGH_PAD_W   = 16 - RESULT_W;
   localparam logic [13:0] RESULT_RESET = 14'h0000;
   localparam logic [7:0]  CMD_SUPPLY_VOLT = 8'h2e;
   localparam logic [7:0]  CMD_CHAN_ONE    = 8'h30;
   localparam logic [7:0]  CMD_CHAN_TWO    = 8'h34;
   localparam logic [7:0]  CMD_CHAN_THREE  = 8'h38;
   localparam logic [7:0]  CMD_CHAN_FOUR   = 8'h3c;
   localparam logic [7:0]  UNMAPPED_BYTE   = 8'h00;

   // Host-side scale of one voltage count, in microvolts; 60 V full scale.
   localparam int VOLTAGE_LSB_WEIGHT_UV = 3662;
   localparam int VOLTAGE_FULL_SCALE_V  = 60;

   // ------------------------------------------------------------------
   // Serial link
   // ------------------------------------------------------------------
   localparam logic [6:0] TARGET_ADDR_DEF = 7'h20;
   localparam logic [3:0] BITS_PER_BYTE   = 4'h8;

   typedef struct packed {
      logic [13:0] supply_voltage_count;
      logic [13:0] chan_one_current_count;
      logic [13:0] chan_two_current_count;
      logic [13:0] chan_three_current_count;
      logic [13:0] chan_four_current_count;
   } ptr_results_s;

   typedef enum logic [3:0] {
      ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_CMD, ST_CMD_ACK,
      ST_RX_DATA, ST_RX_ACK, ST_TX, ST_TX_ACK, ST_TX_NEXT
   } ptr_link_state_e;

   // Selects the result addressed by a command code; unmapped gives zero.
   function automatic logic [13:0] ptr_lookup(input logic [7:0]   cmd,
                                              input ptr_results_s r);
      logic [13:0] v;
      v = RESULT_RESET;
      case (cmd)
         CMD_SUPPLY_VOLT: v = r.supply_voltage_count;
         CMD_CHAN_ONE:    v = r.chan_one_current_count;
         CMD_CHAN_TWO:    v = r.chan_two_current_count;
         CMD_CHAN_THREE:  v = r.chan_three_current_count;
         CMD_CHAN_FOUR:   v = r.chan_four_current_count;
         default:         v = RESULT_RESET;
      endcase
      return v;
   endfunction

   // True for command codes that address a result.
   function automatic logic ptr_mapped(input logic [7:0] cmd);
      return (cmd == CMD_SUPPLY_VOLT) || (cmd == CMD_CHAN_ONE) ||
             (cmd == CMD_CHAN_TWO) || (cmd == CMD_CHAN_THREE) ||
             (cmd == CMD_CHAN_FOUR);
   endfunction

endpackage

//--- rtl/ptr_result_bank.sv
// Result registers refreshed from the converter buses on a slow tick.
// Assumes converter buses are synchronous to sys_clk and hold steady.
module ptr_result_bank
   import ptr_pkg::*;
#(
   parameter int REFRESH_CYCLES = REFRESH_CYCLES_DEF
) (
   // Clock and reset
   input  wire logic         sys_clk,
   input  wire logic         rst,
   // Converter side
   input  wire ptr_results_s conv_results,
   input  wire logic [3:0]   chan_powered,
   // Stored results
   output ptr_results_s      results,
   output logic              refresh_tick
);

   // ------------------------------------------------------------------
   // Refresh divider
   // ------------------------------------------------------------------
   logic [31:0]  div_q;
   logic [31:0]  div_d;
   logic         tick_d;
   logic         tick_q;
   ptr_results_s res_q;
   ptr_results_s res_d;

   always_comb begin
      tick_d = (div_q == 32'(REFRESH_CYCLES - 1));
      div_d  = tick_d ? 32'h0000_0000 : div_q + 32'h0000_0001;
   end

   // ------------------------------------------------------------------
   // Result capture
   // ------------------------------------------------------------------
   always_comb begin
      res_d = res_q;
      if (tick_d) begin // [RULE_11]
         res_d.supply_voltage_count = conv_results.supply_voltage_count;
         // An unpowered channel reports a zero count.
         res_d.chan_one_current_count = chan_powered[0] ?
            conv_results.chan_one_current_count : RESULT_RESET;
         res_d.chan_two_current_count = chan_powered[1] ?
            conv_results.chan_two_current_count : RESULT_RESET;
         res_d.chan_three_current_count = chan_powered[2] ?
            conv_results.chan_three_current_count : RESULT_RESET;
         res_d.chan_four_current_count = chan_powered[3] ?
            conv_results.chan_four_current_count : RESULT_RESET;
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         div_q  <= 32'h0000_0000;
         tick_q <= 1'b0;
         res_q  <= '0; // [RULE_01]
      end else begin
         div_q  <= div_d;
         tick_q <= tick_d;
         res_q  <= res_d;
      end
   end

   assign results      = res_q;
   assign refresh_tick = tick_q;

endmodule

//--- rtl/ptr_telemetry_readout.sv
// Read-only telemetry registers behind a two-wire management target.
// Assumes scl_in and sda_in are already synchronous to sys_clk and that
// the board resolves the open-drain data line from sda_oe.
//
// What this block does
// [RULE_01] Supply voltage is a 14-bit read-only count, zero after reset.
// [RULE_02] Supply voltage read is two bytes; host fetches both for full value.
// [RULE_03] Host scales voltage count by 3.662 mV per step, 60 V full scale.
// [RULE_04] Channel 1 current is read at command 30h, two bytes, read-only.
// [RULE_05] Channel 2 current is read at command 34h, two bytes, read-only.
// [RULE_06] Channel 3 current is read at command 38h, two bytes, read-only.
// [RULE_07] Channel 4 current is read at command 3Ch, two bytes, read-only.
// [RULE_08] Current results go low byte first, high byte second.
// [RULE_09] Low byte holds bits 7..0; high byte bits 13..8, top two zero.
// [RULE_10] Supply voltage is read at command 2Eh, low byte first.
// [RULE_11] Each result refreshes about every 100 ms; 14-bit while powered.
module ptr_telemetry_readout
   import ptr_pkg::*;
#(
   parameter int         REFRESH_CYCLES = REFRESH_CYCLES_DEF,
   parameter logic [6:0] TARGET_ADDR    = TARGET_ADDR_DEF
) (
   // Clock and reset
   input  wire logic         sys_clk,
   input  wire logic         rst,
   // Management link pins
   input  wire logic         scl_in,
   input  wire logic         sda_in,
   output logic              sda_out,
   output logic              sda_oe,
   // Converter result buses
   input  wire ptr_results_s conv_results,
   input  wire logic [3:0]   chan_powered,
   // Status
   output logic              refresh_tick,
   output logic              link_busy
);

   // ------------------------------------------------------------------
   // Result storage
   // ------------------------------------------------------------------
   ptr_results_s results;

   ptr_result_bank #(
      .REFRESH_CYCLES (REFRESH_CYCLES)
   ) u_bank (
      .sys_clk      (sys_clk),
      .rst          (rst),
      .conv_results (conv_results),
      .chan_powered (chan_powered),
      .results      (results),
      .refresh_tick (refresh_tick)
   );

   // ------------------------------------------------------------------
   // Link state
   // ------------------------------------------------------------------
   ptr_link_state_e state_q;
   ptr_link_state_e state_d;
   logic [7:0]      sr_q;
   logic [7:0]      sr_d;
   logic [3:0]      cnt_q;
   logic [3:0]      cnt_d;
   logic            rw_q;
   logic            rw_d;
   logic [7:0]      cmd_q;
   logic [7:0]      cmd_d;
   logic            byte_hi_q;
   logic            byte_hi_d;
   logic [13:0]     snap_q;
   logic [13:0]     snap_d;
   logic            oe_q;
   logic            oe_d;
   logic            scl_q;
   logic            sda_q;

   logic            scl_rise;
   logic            scl_fall;
   logic            start_det;
   logic            stop_det;
   logic [13:0]     sel_value;
   logic [7:0]      tx_byte;

   assign scl_rise  = scl_in & ~scl_q;
   assign scl_fall  = ~scl_in & scl_q;
   assign start_det = scl_in & scl_q & sda_q & ~sda_in;
   assign stop_det  = scl_in & scl_q & ~sda_q & sda_in;

   // ------------------------------------------------------------------
   // Byte to send
   // ------------------------------------------------------------------
   // The low byte snapshots the result so that both halves belong to the
   // same conversion even if a refresh lands between them.
   always_comb begin
      sel_value = ptr_lookup(cmd_q, results); // [RULE_04] [RULE_05]
      if (byte_hi_q) begin // [RULE_08] [RULE_10]
         tx_byte = {{HIGH_PAD_W{1'b0}}, snap_q[RESULT_W-1:8]}; // [RULE_09]
      end else begin
         tx_byte = sel_value[LOW_BYTE_MSB:0]; // [RULE_09]
      end
      if (!ptr_mapped(cmd_q)) begin // [RULE_06] [RULE_07]
         tx_byte = UNMAPPED_BYTE;
      end
   end

   // ------------------------------------------------------------------
   // Next-state logic
   // ------------------------------------------------------------------
   always_comb begin
      state_d   = state_q;
      sr_d      = sr_q;
      cnt_d     = cnt_q;
      rw_d      = rw_q;
      cmd_d     = cmd_q;
      byte_hi_d = byte_hi_q;
      snap_d    = snap_q;
      oe_d      = oe_q;
      if (stop_det) begin
         state_d = ST_IDLE;
         oe_d    = 1'b0;
      end else if (start_det) begin
         state_d = ST_ADDR;
         cnt_d   = 4'h0;
         oe_d    = 1'b0;
      end else begin
         case (state_q)
            ST_IDLE: begin
               oe_d = 1'b0;
            end
            ST_ADDR, ST_CMD, ST_RX_DATA: begin
               if (scl_rise) begin
                  sr_d  = {sr_q[6:0], sda_in};
                  cnt_d = cnt_q + 4'h1;
               end else if (scl_fall && cnt_q == BITS_PER_BYTE) begin
                  cnt_d = 4'h0;
                  oe_d  = 1'b1;
                  if (state_q == ST_ADDR) begin
                     if (sr_q[7:1] == TARGET_ADDR) begin
                        rw_d    = sr_q[0];
                        state_d = ST_ADDR_ACK;
                        // Every read starts on the low byte.
                        if (sr_q[0]) begin
                           byte_hi_d = 1'b0; // [RULE_08]
                        end
                     end else begin
                        oe_d    = 1'b0;
                        state_d = ST_IDLE;
                     end
                  end else if (state_q == ST_CMD) begin
                     cmd_d     = sr_q;
                     byte_hi_d = 1'b0;
                     state_d   = ST_CMD_ACK;
                  end else begin
                     // Written data is acknowledged and dropped.
                     state_d = ST_RX_ACK; // [RULE_01]
                  end
               end
            end
            ST_CMD_ACK, ST_RX_ACK: begin
               if (scl_fall) begin
                  oe_d    = 1'b0;
                  cnt_d   = 4'h0;
                  state_d = ST_RX_DATA;
               end
            end
            ST_ADDR_ACK, ST_TX_NEXT: begin
               if (scl_fall) begin
                  if (state_q == ST_ADDR_ACK && !rw_q) begin
                     oe_d    = 1'b0;
                     state_d = ST_CMD;
                  end else begin
                     if (!byte_hi_q) begin
                        snap_d = sel_value; // [RULE_02]
                     end
                     sr_d    = tx_byte;
                     oe_d    = ~tx_byte[7];
                     cnt_d   = 4'h0;
                     state_d = ST_TX;
                  end
               end
            end
            ST_TX: begin
               if (scl_rise) begin
                  cnt_d = cnt_q + 4'h1;
               end else if (scl_fall) begin
                  if (cnt_q == BITS_PER_BYTE) begin
                     oe_d      = 1'b0;
                     byte_hi_d = ~byte_hi_q; // [RULE_08] [RULE_10]
                     state_d   = ST_TX_ACK;
                  end else begin
                     sr_d = {sr_q[6:0], 1'b0};
                     oe_d = ~sr_q[6];
                  end
               end
            end
            ST_TX_ACK: begin
               if (scl_rise) begin
                  state_d = sda_in ? ST_IDLE : ST_TX_NEXT;
               end
            end
            default: begin
               state_d = ST_IDLE;
               oe_d    = 1'b0;
            end
         endcase
      end
   end

   // ------------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------------
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         state_q   <= ST_IDLE;
         sr_q      <= 8'h00;
         cnt_q     <= 4'h0;
         rw_q      <= 1'b0;
         cmd_q     <= 8'h00;
         byte_hi_q <= 1'b0;
         snap_q    <= RESULT_RESET;
         oe_q      <= 1'b0;
         scl_q     <= 1'b1;
         sda_q     <= 1'b1;
      end else begin
         state_q   <= state_d;
         sr_q      <= sr_d;
         cnt_q     <= cnt_d;
         rw_q      <= rw_d;
         cmd_q     <= cmd_d;
         byte_hi_q <= byte_hi_d;
         snap_q    <= snap_d;
         oe_q      <= oe_d;
         scl_q     <= scl_in;
         sda_q     <= sda_in;
      end
   end

   assign sda_out   = 1'b0;
   assign sda_oe    = oe_q;
   assign link_busy = (state_q != ST_IDLE);

endmodule

//--- verification/ptr_telemetry_readout_assertions.sv
// Checker for the telemetry readout block, bound to its top module.
// Assumes one clock domain and the asynchronous active-high reset.
module ptr_telemetry_readout_assertions
   import ptr_pkg::*;
#(
   parameter int REFRESH_CYCLES = REFRESH_CYCLES_DEF
) (
   // Clock and reset
   input wire logic         sys_clk,
   input wire logic         rst,
   // Link pins
   input wire logic         scl_in,
   input wire logic         sda_in,
   input wire logic         sda_out,
   input wire logic         sda_oe,
   // Converter side and status
   input wire ptr_results_s conv_results,
   input wire logic [3:0]   chan_powered,
   input wire logic         refresh_tick,
   input wire logic         link_busy
);
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (rst);

   // ----------------------------------------------------------------
   // Refresh spacing counter
   // ----------------------------------------------------------------
   int   gap_q;
   int   gap_d;
   logic seen_q;
   logic seen_d;

   always_comb begin
      gap_d  = refresh_tick ? 1 : gap_q + 1;
      seen_d = seen_q | refresh_tick;
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         gap_q  <= 0;
         seen_q <= 1'b0;
      end else begin
         gap_q  <= gap_d;
         seen_q <= seen_d;
      end
   end

   // ----------------------------------------------------------------
   // Properties
   // ----------------------------------------------------------------
   AST_RESET_QUIET: assert property (
      $past(rst) |-> !sda_oe && !link_busy && !refresh_tick)
      else $error("outputs not idle after reset");
   AST_OPEN_DRAIN: assert property (
      sda_oe |-> sda_out == 1'b0) else $error("data line driven high");
   AST_DRIVE_BUSY: assert property (
      sda_oe |-> link_busy) else $error("data line pulled while idle");
   AST_START_SEEN: assert property (
      $rose(link_busy) |-> $past(scl_in) && !$past(sda_in))
      else $error("busy without start condition");
   AST_HOLD_HIGH: assert property (
      scl_in && $past(scl_in) |-> $stable(sda_oe))
      else $error("data changed while clock high");
   // The drive enable moves one edge after the clock fall is seen, so the
   // clock has been low for the current and the previous sample.
   AST_AFTER_FALL: assert property (
      $changed(sda_oe) |-> !scl_in && !$past(scl_in))
      else $error("data changed too soon after clock fall");
   AST_TICK_PULSE: assert property (
      refresh_tick |=> !refresh_tick) else $error("refresh pulse too long");
   AST_TICK_GAP: assert property (
      refresh_tick && seen_q |-> gap_q == REFRESH_CYCLES)
      else $error("refresh spacing wrong");
endmodule

bind ptr_telemetry_readout ptr_telemetry_readout_assertions #(
   .REFRESH_CYCLES(REFRESH_CYCLES)
) chk_u (
   .sys_clk(sys_clk), .rst(rst), .scl_in(scl_in), .sda_in(sda_in),
   .sda_out(sda_out), .sda_oe(sda_oe), .conv_results(conv_results),
   .chan_powered(chan_powered), .refresh_tick(refresh_tick),
   .link_busy(link_busy)
);

//--- verification/ptr_host_model.sv
// Management link controller model acting for the host processor.
// Assumes the bench resolves the data line with a pull-up.
module ptr_host_model
   import ptr_pkg::*;
(
   // Clock
   input wire logic sys_clk,
   // Link
   input wire logic sda_in,
   output logic     scl,
   output logic     sda_pull
);
   timeunit 1ns;
   timeprecision 1ns;
   localparam int HALF = 4;
   logic [6:0] addr = TARGET_ADDR_DEF;

   initial begin
      scl      = 1'b1;
      sda_pull = 1'b0;
   end

   task automatic wait_cyc(input int n);
      repeat (n) @(posedge sys_clk);
   endtask

   // The clock stays high between frames; start also serves as repeat.
   task automatic start();
      sda_pull <= 1'b0;
      wait_cyc(HALF);
      scl <= 1'b1;
      wait_cyc(HALF);
      sda_pull <= 1'b1;
      wait_cyc(HALF);
      scl <= 1'b0;
      wait_cyc(2);
   endtask

   task automatic stop();
      sda_pull <= 1'b1;
      wait_cyc(HALF);
      scl <= 1'b1;
      wait_cyc(HALF);
      sda_pull <= 1'b0;
      wait_cyc(HALF);
   endtask

   task automatic xfer_byte(input logic [7:0] tx, input logic ack_tx,
                            output logic [7:0] rx, output logic ack_rx);
      logic [8:0] sh;
      sh = {tx, ack_tx};
      for (int i = 8; i >= 0; i--) begin
         sda_pull <= ~sh[i];
         wait_cyc(HALF);
         scl <= 1'b1;
         wait_cyc(HALF);
         sh[i] = sda_in;
         scl <= 1'b0;
         wait_cyc(2);
      end
      rx     = sh[8:1];
      ack_rx = sh[0];
   endtask

   task automatic read_reg(input logic [7:0] cmd, output logic [15:0] word,
                           output logic nak);
      logic [7:0] lo;
      logic [7:0] hi;
      logic [7:0] d;
      logic       a0;
      logic       a1;
      logic       a2;
      logic       x;
      start();
      xfer_byte({addr, 1'b0}, 1'b1, d, a0);
      xfer_byte(cmd, 1'b1, d, a1);
      start();
      xfer_byte({addr, 1'b1}, 1'b1, d, a2);
      xfer_byte(8'hff, 1'b0, lo, x);
      xfer_byte(8'hff, 1'b1, hi, x);
      stop();
      word = {hi, lo};
      nak  = a0 | a1 | a2;
   endtask

   task automatic write_reg(input logic [7:0] cmd, input logic [7:0] data,
                            output logic nak);
      logic [7:0] d;
      logic       a0;
      logic       a1;
      logic       a2;
      start();
      xfer_byte({addr, 1'b0}, 1'b1, d, a0);
      xfer_byte(cmd, 1'b1, d, a1);
      xfer_byte(data, 1'b1, d, a2);
      stop();
      nak = a0 | a1 | a2;
   endtask

   function automatic longint to_uv(input logic [13:0] n);
      return longint'(n) * VOLTAGE_LSB_WEIGHT_UV;
   endfunction
endmodule

//--- verification/tb.sv
// Self-checking bench for the telemetry readout block.
// Assumes the host model and the bound checker are compiled alongside.
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin \
   n_fail++; $display("ERROR %s exp %h got %h", nm, e, g); end end

module tb;
   import ptr_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int REFRESH = 1000;
   logic         sys_clk;
   logic         rst;
   logic         scl;
   logic         pull;
   wire          sda;
   logic         sda_out;
   logic         sda_oe;
   logic         refresh_tick;
   logic         link_busy;
   ptr_results_s conv;
   logic [3:0]   powered;
   logic [15:0]  word;
   logic         nak;
   int           n_fail;
   int           num_checks;
   logic [13:0]  vals [5] = '{14'h2a5c, 14'h3fff, 14'h0001, 14'h1234,
                              14'h2000};
   logic [7:0]   cmds [5] = '{CMD_SUPPLY_VOLT, CMD_CHAN_ONE, CMD_CHAN_TWO,
                              CMD_CHAN_THREE, CMD_CHAN_FOUR};

   assign sda = ~(pull | sda_oe);

   ptr_telemetry_readout #(.REFRESH_CYCLES(REFRESH)) dut_u (
      .sys_clk(sys_clk), .rst(rst), .scl_in(scl), .sda_in(sda),
      .sda_out(sda_out), .sda_oe(sda_oe), .conv_results(conv),
      .chan_powered(powered), .refresh_tick(refresh_tick),
      .link_busy(link_busy));

   ptr_host_model host_u (
      .sys_clk(sys_clk), .sda_in(sda), .scl(scl), .sda_pull(pull));

   always #50 sys_clk = ~sys_clk;

   task automatic end_sim();
      if (n_fail == 0 && num_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   initial begin
      repeat (20000) @(posedge sys_clk);
      n_fail++;
      end_sim();
   end

   initial begin
      sys_clk    = 1'b0;
      rst        = 1'b1;
      n_fail     = 0;
      num_checks = 0;
      powered    = 4'hf;
      conv       = {vals[0], vals[1], vals[2], vals[3], vals[4]};
      repeat (16) @(posedge sys_clk);
      rst <= 1'b0;
      repeat (2) @(posedge sys_clk);
      host_u.read_reg(CMD_CHAN_ONE, word, nak);
      `CHK("reset value", 16'h0000, word)
      repeat (REFRESH) @(posedge sys_clk);
      foreach (cmds[i]) begin
         host_u.read_reg(cmds[i], word, nak);
         `CHK("ack", 1'b0, nak)
         `CHK("word", {2'b00, vals[i]}, word)
         `CHK("low byte", vals[i][7:0], word[7:0])
         `CHK("high pad", 2'b00, word[15:14])
      end
      `CHK("scale", 1'b1, host_u.to_uv(14'h3fff) <= 60_000_000)
      powered <= 4'b1011;
      repeat (REFRESH + 10) @(posedge sys_clk);
      host_u.read_reg(CMD_CHAN_THREE, word, nak);
      `CHK("unpowered", 16'h0000, word)
      host_u.write_reg(CMD_CHAN_ONE, 8'ha5, nak);
      `CHK("write ack", 1'b0, nak)
      host_u.read_reg(CMD_CHAN_ONE, word, nak);
      `CHK("read only", {2'b00, vals[1]}, word)
      host_u.read_reg(8'h32, word, nak);
      `CHK("unmapped", 16'h0000, word)
      host_u.addr = TARGET_ADDR_DEF ^ 7'h01;
      host_u.read_reg(CMD_CHAN_ONE, word, nak);
      `CHK("foreign addr", 1'b1, nak)
      host_u.addr = TARGET_ADDR_DEF;
      rst <= 1'b1;
      repeat (2) @(posedge sys_clk);
      rst <= 1'b0;
      repeat (2) @(posedge sys_clk);
      host_u.read_reg(CMD_SUPPLY_VOLT, word, nak);
      `CHK("second reset", 16'h0000, word)
      end_sim();
   end
endmodule
